// ==== nfctcd_pkg.sv ====
// Shared constants and types of the tag command decoder
package nfctcd_pkg;

    // Application command codes
    localparam logic [7:0]  CLA_VENDOR      = 8'hA2;
    localparam logic [7:0]  INS_LONG_READ   = 8'hB0;
    localparam logic [7:0]  INS_LOCK        = 8'h28;
    localparam logic [15:0] LOCK_ATTR_READ  = 16'h0001;
    localparam logic [15:0] LOCK_ATTR_WRITE = 16'h0002;

    // Status words
    localparam logic [15:0] SW_OK          = 16'h9000;
    localparam logic [15:0] SW_WRONG_LEN   = 16'h6700;
    localparam logic [15:0] SW_SECURITY    = 16'h6982;
    localparam logic [15:0] SW_NOT_FOUND   = 16'h6A82;
    localparam logic [15:0] SW_BAD_P1P2    = 16'h6A86;
    localparam logic [15:0] SW_UPDATE_FAIL = 16'h6581;

    // Anticollision codes
    localparam logic [6:0] REQ_ALL     = 7'h52;
    localparam logic [6:0] REQ_SENS    = 7'h26;
    localparam logic [7:0] CMD_SLEEP   = 8'h50;
    localparam logic [7:0] SLEEP_ARG   = 8'h00;
    localparam logic [7:0] SEL_CL1     = 8'h93;
    localparam logic [7:0] SEL_CL2     = 8'h95;
    localparam logic [7:0] NVB_SDD     = 8'h20;
    localparam logic [7:0] NVB_SEL     = 8'h70;
    localparam logic [7:0] CASCADE_TAG = 8'h88;
    localparam logic [7:0] SAK_PARTIAL = 8'h04;
    localparam logic [7:0] SAK_DONE    = 8'h20;
    localparam logic [7:0] ATQA_LO     = 8'h42;
    localparam logic [7:0] ATQA_HI     = 8'h00;

    // Frame lengths in bytes, CRC excluded
    localparam logic [3:0] LEN_SHORT = 4'd1;
    localparam logic [3:0] LEN_SDD   = 4'd2;
    localparam logic [3:0] LEN_LOCK  = 4'd4;
    localparam logic [3:0] LEN_READ  = 4'd5;
    localparam logic [3:0] LEN_SEL   = 4'd7;
    localparam logic [3:0] LEN_OVER  = 4'd8;
    localparam int         FRAME_MAX = 7;
    localparam int         UID_BYTES = 7;
    localparam int         CL_BYTES  = 5;

    // File storage
    localparam int FILE_BYTES = 64;
    localparam int FILE_AW    = 6;

    // Nonvolatile update time
    localparam int CLK_MHZ           = 100;
    localparam int NV_WRITE_TIME_US  = 6000;
    localparam int NV_WRITE_CYCLES   = NV_WRITE_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic [7:0] data;
        logic       short_frame;
    } nfctcd_rxb_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       crc;
        logic       silent;
    } nfctcd_txw_t;

    typedef struct packed {
        logic        selected;
        logic        is_ndef;
        logic [15:0] length;
    } nfctcd_file_t;

    typedef enum logic [1:0] {
        TAG_IDLE, TAG_READY, TAG_ACTIVE, TAG_HALT
    } nfctcd_tag_t;

    typedef enum logic [2:0] {
        C_IDLE, C_FETCH, C_LOAD, C_WAIT, C_NVWAIT
    } nfctcd_core_t;

endpackage

// ==== nfctcd_file_mem.sv ====
// Selected file storage with registered read data
`timescale 1ns/1ps
module nfctcd_file_mem (
    // Clock
    input  wire logic                              clk,
    // Load port
    input  wire logic                              wr_en,
    input  wire logic [nfctcd_pkg::FILE_AW-1:0]    wr_addr,
    input  wire logic [7:0]                        wr_data,
    // Read port
    input  wire logic [nfctcd_pkg::FILE_AW-1:0]    rd_addr,
    output logic      [7:0]                        rd_data
);
    import nfctcd_pkg::*;

    logic [7:0] mem [FILE_BYTES];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // nfctcd_file_mem

// ==== nfctcd_top.sv ====
// Tag command decoder: anticollision and vendor file commands
// Notes on behaviour
// - Class A2 instruction B0 reads selected file at P1-P2 offset, then 90 00.
// - Reads past the stored message but inside the file still succeed.
// - Offset plus length beyond file end gives error status and no data.
// - Read errors: 6700 length, 6982 security, 6A82 no file, 6A86 offset.
// - Class A2 instruction 28 locks file read-only or write-only forever.
// - Lock answer waits about 6 ms for the nonvolatile write.
// - Lock answers no data: 9000, 6581, 6700, 6982, 6A82 or 6A86.
// - Recognise 7-bit 52 and 26, sleep 50, and 93 or 95 selects.
// - Code 93 is cascade level 1, 95 is level 2.
// - Anticollision with parameter 20 sends the whole level identifier.
// - Identifier has 7 bytes; each level answer has 5 bytes.
// - Level 1 is 88, uid1..3, check; level 2 is uid4..7, check.
// - Matching select with 70 answers 04 at level 1, 20 at level 2.
`timescale 1ns/1ps
module nfctcd_top #(
    parameter int                NV_CYCLES = nfctcd_pkg::NV_WRITE_CYCLES,
    // Identifier value is arbitrary
    parameter logic [0:6][7:0]   UID       = 56'h04_1A_2B_3C_4D_5E_6F
) (
    // Core clock and reset
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // Link clock recovered from the field
    input  wire logic                      link_clk,
    // Received frame bytes, link clock
    input  wire logic                      rx_valid,
    input  wire nfctcd_pkg::nfctcd_rxb_t   rx_byte,
    input  wire logic                      rx_end,
    // Response bytes, link clock
    output logic                           tx_valid,
    output nfctcd_pkg::nfctcd_txw_t        tx_word,
    input  wire logic                      tx_ready,
    // File selection and access state
    input  wire nfctcd_pkg::nfctcd_file_t  file_info,
    input  wire logic                      read_granted,
    input  wire logic                      write_granted,
    // Nonvolatile lock state
    input  wire logic                      nv_ro_init,
    input  wire logic                      nv_wo_init,
    input  wire logic                      nv_fail,
    output logic                           nv_write,
    output logic                           locked_read_only_state,
    output logic                           locked_write_only_state,
    // File contents load
    input  wire logic                      mem_wr_en,
    input  wire logic [5:0]                mem_wr_addr,
    input  wire logic [7:0]                mem_wr_data
);
    import nfctcd_pkg::*;

    // Reset release in both domains
    logic [1:0] rst_sync;
    logic [1:0] lrst_sync;
    wire        rst_n  = rst_sync[1];
    wire        lrst_n = lrst_sync[1];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) rst_sync <= 2'b00;
        else         rst_sync <= {rst_sync[0], 1'b1};
    end

    always_ff @(posedge link_clk or negedge resetn) begin
        if (!resetn) lrst_sync <= 2'b00;
        else         lrst_sync <= {lrst_sync[0], 1'b1};
    end

    // ---------------- Link domain ----------------
    logic [0:6][7:0] frm;
    logic [3:0]      frm_cnt;
    logic            frm_short;
    logic            busy;
    logic            req_tg;
    logic [1:0]      w_sync;
    logic            w_seen;
    logic            w_tg;
    nfctcd_txw_t     txw;

    wire pending   = w_sync[1] != w_seen;
    wire take_word = pending && (txw.silent || tx_ready);
    wire frame_fin = take_word && (txw.silent || txw.last);
    wire rx_take   = rx_valid && !busy;
    wire [2:0] wr_idx = frm_cnt[2:0];

    assign tx_valid = pending && !txw.silent;
    assign tx_word  = '{data: txw.data, last: txw.last, crc: txw.crc,
                        silent: 1'b0};

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            frm       <= '0;
            frm_cnt   <= 4'd0;
            frm_short <= 1'b0;
        end else if (frame_fin) begin
            frm_cnt   <= 4'd0;
        end else if (rx_take && frm_cnt != LEN_OVER) begin
            if (frm_cnt < LEN_SEL) frm[wr_idx] <= rx_byte.data;
            frm_cnt   <= frm_cnt + 4'd1;
            frm_short <= rx_byte.short_frame;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            busy   <= 1'b0;
            req_tg <= 1'b0;
            w_sync <= 2'b00;
            w_seen <= 1'b0;
        end else begin
            w_sync <= {w_sync[0], w_tg};
            if (rx_end && !busy) begin
                busy   <= 1'b1;
                req_tg <= ~req_tg;
            end else if (frame_fin) begin
                busy   <= 1'b0;
            end
            if (take_word) w_seen <= w_sync[1];
        end
    end

    // ---------------- Core domain ----------------
    logic [1:0]   req_sync;
    logic         req_seen;
    logic [1:0]   ack_sync;
    nfctcd_core_t cst;
    nfctcd_tag_t  tag;
    logic         cl1_done;
    logic         init_done;
    logic [0:4][7:0] fix;
    logic [2:0]   fix_len;
    logic [8:0]   data_cnt;
    logic [8:0]   idx;
    logic         resp_crc;
    logic [23:0]  nv_cnt;
    logic         nv_lock_ro;
    logic [7:0]   mem_q;

    wire new_frame = req_sync[1] != req_seen;
    wire ack_back  = ack_sync[1] == w_tg;

    // Frame fields, stable while the link side is busy
    wire [7:0]  b0      = frm[0];
    wire [7:0]  b1      = frm[1];
    wire [15:0] p1p2    = {frm[2], frm[3]};
    wire [7:0]  le      = frm[4];
    wire [16:0] rd_end  = {1'b0, p1p2} + {9'd0, le};

    // Identifier levels with check bytes
    wire [7:0] bcc1 = CASCADE_TAG ^ UID[0] ^ UID[1] ^ UID[2];
    wire [7:0] bcc2 = UID[3] ^ UID[4] ^ UID[5] ^ UID[6];
    wire [0:4][7:0] cl1 = {CASCADE_TAG, UID[0], UID[1], UID[2], bcc1};
    wire [0:4][7:0] cl2 = {UID[3], UID[4], UID[5], UID[6], bcc2};

    // Anticollision decode
    wire lvl1     = b0 == SEL_CL1;
    wire lvl2     = b0 == SEL_CL2 && cl1_done;
    wire [0:4][7:0] cl_pick = lvl1 ? cl1 : cl2;
    wire is_short = frm_short && frm_cnt == LEN_SHORT;
    wire asleep   = tag == TAG_IDLE || tag == TAG_HALT;
    wire wake     = asleep && is_short && (b0[6:0] == REQ_ALL ||
                    (b0[6:0] == REQ_SENS && tag == TAG_IDLE));
    wire sleep    = !asleep && frm_cnt == LEN_SDD &&
                    b0 == CMD_SLEEP && b1 == SLEEP_ARG;
    wire sdd      = (lvl1 || lvl2) && frm_cnt == LEN_SDD &&
                    b1 == NVB_SDD;
    wire sel      = (lvl1 || lvl2) && frm_cnt == LEN_SEL &&
                    b1 == NVB_SEL && frm[2:6] == cl_pick;

    // Vendor command decode
    wire vendor   = tag == TAG_ACTIVE && b0 == CLA_VENDOR &&
                    frm_cnt >= LEN_SDD;
    wire is_read  = vendor && b1 == INS_LONG_READ;
    wire is_lock  = vendor && b1 == INS_LOCK;
    wire any_lock = locked_read_only_state || locked_write_only_state;
    wire attr_ok  = p1p2 == LOCK_ATTR_READ || p1p2 == LOCK_ATTR_WRITE;

    wire [15:0] rd_sw =
        !file_info.selected                  ? SW_NOT_FOUND :
        (frm_cnt != LEN_READ || le == 8'h00) ? SW_WRONG_LEN :
        (locked_write_only_state || !read_granted) ? SW_SECURITY :
        (p1p2 >= file_info.length)           ? SW_BAD_P1P2 :
        (rd_end > {1'b0, file_info.length})  ? SW_WRONG_LEN :
                                               SW_OK;

    wire [15:0] lk_sw =
        (!file_info.selected || !file_info.is_ndef) ? SW_NOT_FOUND :
        (frm_cnt != LEN_LOCK)                ? SW_WRONG_LEN :
        (!write_granted || any_lock)         ? SW_SECURITY :
        !attr_ok                             ? SW_BAD_P1P2 :
                                               SW_OK;

    // Response chosen for a new frame
    logic [0:4][7:0] dec_b;
    logic [2:0]      dec_len;
    logic [8:0]      dec_cnt;
    logic            dec_crc;
    logic            dec_nv;
    nfctcd_tag_t     next_tag;
    logic            next_cl1;

    always_comb begin
        dec_b    = '0;
        dec_len  = 3'd0;
        dec_cnt  = 9'd0;
        dec_crc  = 1'b1;
        dec_nv   = 1'b0;
        next_tag = tag;
        next_cl1 = cl1_done;
        if (wake) begin
            next_tag = TAG_READY;
            next_cl1 = 1'b0;
            dec_b[0] = ATQA_LO;
            dec_b[1] = ATQA_HI;
            dec_len  = 3'd2;
            dec_crc  = 1'b0;
        end else if (sleep) begin
            next_tag = TAG_HALT;
        end else if (tag == TAG_READY) begin
            if (sdd) begin
                dec_b   = cl_pick;
                dec_len = 3'd5;
                dec_crc = 1'b0;
            end else if (sel && lvl1) begin
                dec_b[0] = SAK_PARTIAL;
                dec_len  = 3'd1;
                next_cl1 = 1'b1;
            end else if (sel) begin
                dec_b[0] = SAK_DONE;
                dec_len  = 3'd1;
                next_tag = TAG_ACTIVE;
            end else begin
                next_tag = TAG_IDLE;
            end
        end else if (is_read) begin
            dec_b[0] = rd_sw[15:8];
            dec_b[1] = rd_sw[7:0];
            dec_len  = 3'd2;
            if (rd_sw == SW_OK) dec_cnt = {1'b0, le};
        end else if (is_lock) begin
            if (lk_sw == SW_OK) begin
                dec_nv = 1'b1;
            end else begin
                dec_b[0] = lk_sw[15:8];
                dec_b[1] = lk_sw[7:0];
                dec_len  = 3'd2;
            end
        end
    end

    // Byte being sent: file data first, then the fixed part
    wire [8:0] total   = data_cnt + {6'd0, fix_len};
    wire [8:0] fix_pos = idx - data_cnt;
    wire [2:0] fix_sel = fix_pos[2:0];
    wire       in_data = idx < data_cnt;
    wire [15:0] rd_addr_w = p1p2 + {7'd0, idx};
    wire       nv_done = nv_cnt == 24'(NV_CYCLES - 1);

    nfctcd_file_mem u_mem (
        .clk     (clk),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (mem_wr_data),
        .rd_addr (rd_addr_w[FILE_AW-1:0]),
        .rd_data (mem_q)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_sync <= 2'b00;
            ack_sync <= 2'b00;
        end else begin
            req_sync <= {req_sync[0], req_tg};
            ack_sync <= {ack_sync[0], w_seen};
        end
    end

    // Lock state loaded once after reset, then set only by the command
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done               <= 1'b0;
            locked_read_only_state  <= 1'b0;
            locked_write_only_state <= 1'b0;
        end else if (!init_done) begin
            init_done               <= 1'b1;
            locked_read_only_state  <= nv_ro_init;
            locked_write_only_state <= nv_wo_init;
        end else if (cst == C_NVWAIT && nv_done && !nv_fail) begin
            locked_read_only_state  <= locked_read_only_state | nv_lock_ro;
            locked_write_only_state <= locked_write_only_state
                                       | !nv_lock_ro;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cst        <= C_IDLE;
            tag        <= TAG_IDLE;
            cl1_done   <= 1'b0;
            req_seen   <= 1'b0;
            w_tg       <= 1'b0;
            txw        <= '0;
            fix        <= '0;
            fix_len    <= 3'd0;
            data_cnt   <= 9'd0;
            idx        <= 9'd0;
            resp_crc   <= 1'b0;
            nv_cnt     <= 24'd0;
            nv_lock_ro <= 1'b0;
            nv_write   <= 1'b0;
        end else begin
            nv_write <= 1'b0;
            case (cst)
                C_IDLE: begin
                    if (new_frame && init_done) begin
                        req_seen   <= req_sync[1];
                        tag        <= next_tag;
                        cl1_done   <= next_cl1;
                        fix        <= dec_b;
                        fix_len    <= dec_len;
                        data_cnt   <= dec_cnt;
                        resp_crc   <= dec_crc;
                        idx        <= 9'd0;
                        nv_cnt     <= 24'd0;
                        nv_lock_ro <= p1p2 == LOCK_ATTR_WRITE;
                        nv_write   <= dec_nv;
                        cst        <= dec_nv ? C_NVWAIT : C_FETCH;
                    end
                end
                C_NVWAIT: begin
                    nv_cnt <= nv_cnt + 24'd1;
                    if (nv_done) begin
                        fix[0]  <= nv_fail ? SW_UPDATE_FAIL[15:8]
                                           : SW_OK[15:8];
                        fix[1]  <= nv_fail ? SW_UPDATE_FAIL[7:0]
                                           : SW_OK[7:0];
                        fix_len <= 3'd2;
                        cst     <= C_FETCH;
                    end
                end
                C_FETCH: begin
                    cst <= C_LOAD;
                end
                C_LOAD: begin
                    txw.data   <= in_data ? mem_q : fix[fix_sel];
                    txw.last   <= idx == total - 9'd1;
                    txw.crc    <= resp_crc;
                    txw.silent <= total == 9'd0;
                    w_tg       <= ~w_tg;
                    cst        <= C_WAIT;
                end
                C_WAIT: begin
                    if (ack_back) begin
                        idx <= idx + 9'd1;
                        cst <= (txw.last || txw.silent) ? C_IDLE : C_FETCH;
                    end
                end
                default: begin
                    cst <= C_IDLE;
                end
            endcase
        end
    end

endmodule // nfctcd_top

// ==== nfctcd_checker.sv ====
// Port assertions of the tag command decoder
`timescale 1ns/1ps
module nfctcd_checker
    import nfctcd_pkg::*;
#(
    parameter int NV_CYCLES = 50
) (
    // Clocks and reset
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        link_clk,
    // Answer side
    input wire logic        tx_valid,
    input wire nfctcd_txw_t tx_word,
    input wire logic        tx_ready,
    // Lock side
    input wire logic        nv_write,
    input wire logic        locked_read_only_state,
    input wire logic        locked_write_only_state
);
    int since_nv;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            since_nv <= NV_CYCLES;
        else if (nv_write)
            since_nv <= 0;
        else if (since_nv < NV_CYCLES)
            since_nv <= since_nv + 1;
    end
    property p_tx_hold;
        @(posedge link_clk) disable iff (!resetn)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_word);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("answer word dropped before accept");
    property p_tx_loud;
        @(posedge link_clk) disable iff (!resetn)
        tx_valid |-> !tx_word.silent;
    endproperty
    a_tx_loud: assert property (p_tx_loud)
        else $error("silent word at port");
    property p_tx_end;
        @(posedge link_clk) disable iff (!resetn)
        tx_valid && tx_ready && tx_word.last |=> !tx_valid;
    endproperty
    a_tx_end: assert property (p_tx_end)
        else $error("word after last of answer");
    property p_nv_pulse;
        @(posedge clk) disable iff (!resetn) nv_write |=> !nv_write;
    endproperty
    a_nv_pulse: assert property (p_nv_pulse)
        else $error("nv write pulse too long");
    property p_nv_wait;
        @(posedge clk) disable iff (!resetn)
        $rose(locked_read_only_state) || $rose(locked_write_only_state)
            |-> since_nv >= NV_CYCLES - 2;
    endproperty
    a_nv_wait: assert property (p_nv_wait)
        else $error("lock set before write time");
    property p_nv_free;
        @(posedge clk) disable iff (!resetn)
        nv_write |-> !locked_read_only_state && !locked_write_only_state;
    endproperty
    a_nv_free: assert property (p_nv_free)
        else $error("second lock write");
    property p_ro_keep;
        @(posedge clk) disable iff (!resetn)
        locked_read_only_state |=> locked_read_only_state;
    endproperty
    a_ro_keep: assert property (p_ro_keep)
        else $error("read-only lock lost");
    property p_wo_keep;
        @(posedge clk) disable iff (!resetn)
        locked_write_only_state |=> locked_write_only_state;
    endproperty
    a_wo_keep: assert property (p_wo_keep)
        else $error("write-only lock lost");
endmodule // nfctcd_checker
bind nfctcd_top nfctcd_checker #(.NV_CYCLES(NV_CYCLES)) chk_u (.clk, .resetn,
    .link_clk, .tx_valid, .tx_word, .tx_ready, .nv_write,
    .locked_read_only_state, .locked_write_only_state);

// ==== nfctcd_reader_model.sv ====
// Reader-side model: sends frames and takes the tag's answers
`timescale 1ns/1ps
module nfctcd_reader_model
    import nfctcd_pkg::*;
(
    // Link clock
    input  wire logic        link_clk,
    // Frames to the tag
    output logic             rx_valid,
    output nfctcd_rxb_t      rx_byte,
    output logic             rx_end,
    // Answers from the tag
    input  wire logic        tx_valid,
    input  wire nfctcd_txw_t tx_word,
    output logic             tx_ready
);
    logic [7:0] resp[$];
    logic       crc_seen;
    logic       slow = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_end = 1'b0;
        rx_byte = '0;
        tx_ready = 1'b0;
    end
    // Frame bytes come from the caller; SDD holds code and 20 only
    task automatic xfer(input logic [0:6][7:0] f, input int n,
                        input logic sh, input int lim);
        logic        got;
        nfctcd_txw_t word;
        resp.delete();
        for (int i = 0; i < n; i++) begin
            @(negedge link_clk);
            rx_valid = 1'b1;
            rx_byte = '{data: f[i], short_frame: sh};
        end
        @(negedge link_clk);
        rx_valid = 1'b0;
        rx_byte.data = ~rx_byte.data; // No stale byte left on the lines
        rx_end = 1'b1;
        @(negedge link_clk);
        rx_end = 1'b0;
        for (int w = 0; w < lim; w++) begin
            @(negedge link_clk);
            tx_ready = !slow || w[0];
            // Settled answer taken before the accepting edge
            got = tx_valid === 1'b1 && tx_ready;
            word = tx_word;
            @(posedge link_clk);
            if (got) begin
                resp.push_back(word.data);
                crc_seen = word.crc;
                if (word.last === 1'b1)
                    break;
            end
        end
        @(negedge link_clk);
        tx_ready = 1'b0;
    endtask
endmodule // nfctcd_reader_model

// ==== nfctcd_tb_top.sv ====
// Testbench of the tag command decoder
`timescale 1ns/1ps
module nfctcd_tb_top;
    import nfctcd_pkg::*;
    localparam int NV = 50;
    // Identifier value is arbitrary
    localparam logic [0:6][7:0] UID_V = 56'h05_11_22_33_44_55_66;
    logic         clk = 1'b0, link_clk = 1'b0, resetn = 1'b0;
    logic         rx_valid, rx_end, tx_valid, tx_ready, nv_write;
    logic         locked_read_only_state, locked_write_only_state;
    logic         read_granted = 1'b1, write_granted = 1'b0;
    logic         nv_fail = 1'b0, mem_wr_en = 1'b0;
    logic [5:0]   mem_wr_addr = '0;
    logic [7:0]   mem_wr_data = '0;
    nfctcd_rxb_t  rx_byte;
    nfctcd_txw_t  tx_word;
    nfctcd_file_t file_info = '{1'b1, 1'b1, 16'd64};
    int           n_fail = 0, tests_run = 0, cyc = 0;
    time          t_nv = 0;
    nfctcd_top #(.NV_CYCLES(NV), .UID(UID_V)) dut_u (.clk, .resetn,
        .link_clk, .rx_valid, .rx_byte, .rx_end, .tx_valid, .tx_word,
        .tx_ready, .file_info, .read_granted, .write_granted,
        .nv_ro_init(1'b0), .nv_wo_init(1'b0), .nv_fail, .nv_write,
        .locked_read_only_state, .locked_write_only_state, .mem_wr_en,
        .mem_wr_addr, .mem_wr_data);
    nfctcd_reader_model rdr (.link_clk, .rx_valid, .rx_byte, .rx_end,
        .tx_valid, .tx_word, .tx_ready);
    always #5 clk = ~clk;
    initial begin
        #3.3;
        forever #15 link_clk = ~link_clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (nv_write === 1'b1)
            t_nv = $time;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic run(input logic [0:6][7:0] f, input int n, input logic sh,
                       input logic [0:8][7:0] e, input int ne,
                       input logic c, input int lim);
        rdr.xfer(f, n, sh, lim);
        chk(rdr.resp.size() == ne, "answer length");
        for (int i = 0; i < ne && i < rdr.resp.size(); i++)
            chk(rdr.resp[i] === e[i], "answer byte");
        if (ne > 0)
            chk(rdr.crc_seen === c, "crc flag");
    endtask
    task automatic rd(input logic [15:0] off, input logic [7:0] le,
                      input logic [15:0] sw);
        run({16'hA2B0, off, le, 16'h0}, 5, 1'b0, {sw, 56'h0}, 2, 1'b1, 400);
    endtask
    task automatic lk(input logic [15:0] p, input logic [15:0] sw);
        run({16'hA228, p, 24'h0}, 4, 1'b0, {sw, 56'h0}, 2, 1'b1, 400);
    endtask
    task automatic activate(input logic [7:0] req);
        logic [7:0] c1, c2;
        c1 = 8'h88 ^ UID_V[0] ^ UID_V[1] ^ UID_V[2];
        c2 = UID_V[3] ^ UID_V[4] ^ UID_V[5] ^ UID_V[6];
        run({req, 48'h0}, 1, 1'b1, {16'h4200, 56'h0}, 2, 1'b0, 400);
        run({16'h9320, 40'h0}, 2, 1'b0, {8'h88, UID_V[0:2], c1, 32'h0},
            5, 1'b0, 400);
        run({16'h9370, 8'h88, UID_V[0:2], c1}, 7, 1'b0, {8'h04, 64'h0},
            1, 1'b1, 400);
        run({16'h9520, 40'h0}, 2, 1'b0, {UID_V[3:6], c2, 32'h0}, 5,
            1'b0, 400);
        run({16'h9570, UID_V[3:6], c2}, 7, 1'b0, {8'h20, 64'h0}, 1,
            1'b1, 400);
    endtask
    task automatic t_anticoll();
        activate(8'h26);
        run({16'h5000, 40'h0}, 2, 1'b0, '0, 0, 1'b0, 60);
        run({8'h26, 48'h0}, 1, 1'b1, '0, 0, 1'b0, 60);
        activate(8'h52);
        $display("anticollision test done");
    endtask
    task automatic t_read();
        logic [0:8][7:0] e;
        e = '0;
        for (int i = 0; i < 4; i++)
            e[i] = 8'((60 + i) * 7 + 3);
        e[4] = 8'h90;
        rdr.slow = 1'b1;
        run({40'hA2B0003C04, 16'h0}, 5, 1'b0, e, 6, 1'b1, 400);
        rdr.slow = 1'b0;
        rd(16'h003E, 8'h04, 16'h6700);
        rd(16'h0040, 8'h01, 16'h6A86);
        rd(16'h0000, 8'h00, 16'h6700);
        @(negedge clk);
        read_granted = 1'b0;
        rd(16'h0000, 8'h01, 16'h6982);
        @(negedge clk);
        read_granted = 1'b1;
        file_info.selected = 1'b0;
        rd(16'h0000, 8'h01, 16'h6A82);
        @(negedge clk);
        file_info.selected = 1'b1;
        $display("read test done");
    endtask
    task automatic t_lock();
        lk(16'h0001, 16'h6982);
        @(negedge clk);
        write_granted = 1'b1;
        lk(16'h0003, 16'h6A86);
        @(negedge clk);
        nv_fail = 1'b1;
        lk(16'h0001, 16'h6581);
        chk(locked_write_only_state === 1'b0, "lock after failed write");
        @(negedge clk);
        nv_fail = 1'b0;
        lk(16'h0002, 16'h9000);
        chk(t_nv > 0 && $time - t_nv >= NV * 10, "answer too early");
        chk(locked_read_only_state === 1'b1, "read-only lock missing");
        lk(16'h0001, 16'h6982);
        chk(locked_write_only_state === 1'b0, "second lock taken");
        $display("lock test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 64; i++) begin
            @(negedge clk);
            mem_wr_en = 1'b1;
            mem_wr_addr = 6'(i);
            mem_wr_data = 8'(i * 7 + 3);
        end
        @(negedge clk);
        mem_wr_en = 1'b0;
        t_anticoll();
        t_read();
        t_lock();
        close_out();
    end
endmodule // nfctcd_tb_top
